// *** rtl/alop_core.v ***
// The address-and-strobe port and the address map were left to the implementer.
`include "alop_defs.vh"
// Contract
// - add_literal adds the 8-bit literal to W and writes the sum back to W.
// - the literal of add_literal and and_literal is an unsigned value 0 to 255.
// - both additions update carry, nibble carry and zero from the sum.
// - add_literal is decoded as 11 111x kkkk kkkk, x ignored, low byte the literal.
// - add_register sums W and file f, result to W when d is 0, to f when d is 1.
// - the addition always uses current W and the file addressed by the 7-bit field.
// - add_register is decoded as 00 0111 dfff ffff.
// - and_literal stores W AND literal into W.
// - and_literal changes only the zero flag.
// - and_literal is decoded as 11 1001 kkkk kkkk.
// - each instruction is one word, one cycle: decode Q1, read Q2, process Q3, write Q4.
// - one instruction cycle spans four clock periods, one per phase.
module alop_core (
  // clock and reset
  input  wire        CLK,
  input  wire        RST,
  // instruction from fetch
  input  wire [13:0] INSTR,
  // file register port
  output wire [6:0]  FILE_ADDR,
  input  wire [7:0]  FILE_RDATA,
  output reg  [7:0]  FILE_WDATA,
  output reg         FILE_WE,
  // phase and state
  output wire [1:0]  PHASE,
  output wire        INSTR_START,
  output wire [7:0]  W_REG,
  output wire        CARRY_FLAG,
  output wire        NIBBLE_CARRY_FLAG,
  output wire        ZERO_FLAG,
  output wire        ILLEGAL_OP
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function match_op;
    input [13:0] word;
    input [13:0] mask;
    input [13:0] pat;
    begin
      match_op = ((word & mask) == pat);
    end
  endfunction

  localparam [1:0] OP_NONE = 2'h0;
  localparam [1:0] OP_ADDL = 2'h1;
  localparam [1:0] OP_ADDF = 2'h2;
  localparam [1:0] OP_ANDL = 2'h3;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [1:0]  phase_ff;
  reg [13:0] instr_ff;
  reg [1:0]  op_ff;
  reg [7:0]  opnd_ff;
  reg [7:0]  res_ff;
  reg        res_c_ff;
  reg        res_dc_ff;
  reg [7:0]  w_ff;
  reg        c_ff;
  reg        dc_ff;
  reg        z_ff;
  reg        dest_f_ff;
  reg        illegal_ff;
  reg [1:0]  nxt_op;
  reg [1:0]  nxt_phase;

  wire [7:0] add_sum;
  wire       add_c;
  wire       add_dc;

  assign PHASE             = phase_ff;
  assign INSTR_START       = (phase_ff == `ALOP_PH_Q1);
  assign W_REG             = w_ff;
  assign CARRY_FLAG        = c_ff;
  assign NIBBLE_CARRY_FLAG = dc_ff;
  assign ZERO_FLAG         = z_ff;
  assign ILLEGAL_OP        = illegal_ff;
  assign FILE_ADDR         = instr_ff[`ALOP_FADDR_MSB:0];

  // ---------------------------------------------------------------
  // phase sequencer: four clocks per instruction cycle
  // ---------------------------------------------------------------
  always @* begin
    case (phase_ff)
      `ALOP_PH_Q1: nxt_phase = `ALOP_PH_Q2;
      `ALOP_PH_Q2: nxt_phase = `ALOP_PH_Q3;
      `ALOP_PH_Q3: nxt_phase = `ALOP_PH_Q4;
      `ALOP_PH_Q4: nxt_phase = `ALOP_PH_Q1;
      default:     nxt_phase = `ALOP_PH_Q1;
    endcase
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_ff <= `ALOP_PH_Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // ---------------------------------------------------------------
  // Q1 decode
  // ---------------------------------------------------------------
  always @* begin
    if (match_op(INSTR, `ALOP_ADD_LIT_MASK, `ALOP_ADD_LIT_MATCH)) begin
      nxt_op = OP_ADDL;
    end else if (match_op(INSTR, `ALOP_AND_LIT_MASK, `ALOP_AND_LIT_MATCH)) begin
      nxt_op = OP_ANDL;
    end else if (match_op(INSTR, `ALOP_ADD_REG_MASK, `ALOP_ADD_REG_MATCH)) begin
      nxt_op = OP_ADDF;
    end else begin
      nxt_op = OP_NONE;
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      instr_ff   <= 14'h0000;
      op_ff      <= OP_NONE;
      dest_f_ff  <= 1'h0;
      illegal_ff <= 1'h0;
    end else if (phase_ff == `ALOP_PH_Q1) begin
      instr_ff   <= INSTR;
      op_ff      <= nxt_op;
      dest_f_ff  <= INSTR[`ALOP_DEST_BIT];
      illegal_ff <= (nxt_op == OP_NONE);
    end
  end

  // ---------------------------------------------------------------
  // Q2 operand read: literal or file register
  // ---------------------------------------------------------------
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      opnd_ff <= 8'h00;
    end else if (phase_ff == `ALOP_PH_Q2) begin
      if (op_ff == OP_ADDF) begin
        opnd_ff <= FILE_RDATA;
      end else begin
        opnd_ff <= instr_ff[`ALOP_LIT_MSB:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Q3 processing
  // ---------------------------------------------------------------
  alop_adder u_adder (
    .a            (w_ff),
    .b            (opnd_ff),
    .sum          (add_sum),
    .carry        (add_c),
    .nibble_carry (add_dc)
  );

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      res_ff    <= 8'h00;
      res_c_ff  <= 1'h0;
      res_dc_ff <= 1'h0;
    end else if (phase_ff == `ALOP_PH_Q3) begin
      case (op_ff)
        OP_ADDL, OP_ADDF: begin
          res_ff    <= add_sum;
          res_c_ff  <= add_c;
          res_dc_ff <= add_dc;
        end
        OP_ANDL: begin
          res_ff    <= w_ff & opnd_ff;
          res_c_ff  <= c_ff;
          res_dc_ff <= dc_ff;
        end
        default: begin
          res_ff    <= w_ff;
          res_c_ff  <= c_ff;
          res_dc_ff <= dc_ff;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Q4 write to destination and flags
  // ---------------------------------------------------------------
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      w_ff  <= `ALOP_W_RESET;
      c_ff  <= `ALOP_FLAG_RESET;
      dc_ff <= `ALOP_FLAG_RESET;
      z_ff  <= `ALOP_FLAG_RESET;
    end else if (phase_ff == `ALOP_PH_Q4) begin
      case (op_ff)
        OP_ADDL: begin
          w_ff  <= res_ff;
          c_ff  <= res_c_ff;
          dc_ff <= res_dc_ff;
          z_ff  <= (res_ff == 8'h00);
        end
        OP_ADDF: begin
          if (!dest_f_ff) begin
            w_ff <= res_ff;
          end
          c_ff  <= res_c_ff;
          dc_ff <= res_dc_ff;
          z_ff  <= (res_ff == 8'h00);
        end
        OP_ANDL: begin
          w_ff <= res_ff;
          z_ff <= (res_ff == 8'h00);
        end
        default: begin
          w_ff <= w_ff;
        end
      endcase
    end
  end

  // file write strobe and data for add_register with d = 1
  always @* begin
    FILE_WE    = (phase_ff == `ALOP_PH_Q4) && (op_ff == OP_ADDF) && dest_f_ff;
    FILE_WDATA = res_ff;
  end

endmodule

// *** rtl/alop_defs.vh ***
`ifndef ALOP_DEFS_VH
`define ALOP_DEFS_VH

// ---------------------------------------------------------------
// opcode decode patterns (14-bit instruction word)
// ---------------------------------------------------------------
`define ALOP_ADD_LIT_MASK  14'h3e00
`define ALOP_ADD_LIT_MATCH 14'h3e00
`define ALOP_AND_LIT_MASK  14'h3f00
`define ALOP_AND_LIT_MATCH 14'h3900
`define ALOP_ADD_REG_MASK  14'h3f00
`define ALOP_ADD_REG_MATCH 14'h0700

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ALOP_LIT_MSB       7
`define ALOP_FADDR_MSB     6
`define ALOP_DEST_BIT      7

// ---------------------------------------------------------------
// phase encoding and reset values
// ---------------------------------------------------------------
`define ALOP_PH_Q1         2'h0
`define ALOP_PH_Q2         2'h1
`define ALOP_PH_Q3         2'h2
`define ALOP_PH_Q4         2'h3
`define ALOP_W_RESET       8'h00
`define ALOP_FLAG_RESET    1'h0

`endif

// *** rtl/alop_adder.v ***
// ---------------------------------------------------------------
// 8-bit adder with carry out of bit 3 and bit 7
// ---------------------------------------------------------------
module alop_adder (
  // operands
  input  wire [7:0] a,
  input  wire [7:0] b,
  // results
  output wire [7:0] sum,
  output wire       carry,
  output wire       nibble_carry
);

  wire [4:0] low_sum;
  wire [8:0] full_sum;

  // low nibble gives the nibble carry, full sum the carry
  assign low_sum      = {1'b0, a[3:0]} + {1'b0, b[3:0]};
  assign full_sum     = {1'b0, a} + {1'b0, b};
  assign sum          = full_sum[7:0];
  assign carry        = full_sum[8];
  assign nibble_carry = low_sum[4];

endmodule

// *** verif/alop_checker.sv ***
module alop_checker (
  // clock and reset
  input logic        CLK,
  input logic        RST,
  // fetch and file port
  input logic [13:0] INSTR,
  input logic [6:0]  FILE_ADDR,
  input logic [7:0]  FILE_RDATA,
  input logic [7:0]  FILE_WDATA,
  input logic        FILE_WE,
  // core state
  input logic [1:0]  PHASE,
  input logic        INSTR_START,
  input logic [7:0]  W_REG,
  input logic        CARRY_FLAG,
  input logic        NIBBLE_CARRY_FLAG,
  input logic        ZERO_FLAG,
  input logic        ILLEGAL_OP
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // phase sequencing and operand pickup
  a_phase_steps: assert property (PHASE != 2'h0 |-> PHASE == $past(PHASE) + 2'h1)
    else $error("phase skipped");
  a_start_level: assert property (INSTR_START == (PHASE == 2'h0))
    else $error("start flag off phase");
  a_file_addr: assert property (PHASE == 2'h1 |-> FILE_ADDR == $past(INSTR[6:0]))
    else $error("file address wrong");
  // results of each operation
  a_and_keeps: assert property (PHASE == 2'h0 && INSTR[13:8] == 6'h39
    |=> $stable({CARRY_FLAG, NIBBLE_CARRY_FLAG})[*4]) else $error("and moved carry");
  a_and_result: assert property (PHASE == 2'h0 && INSTR[13:8] == 6'h39 |-> ##4
    W_REG == ($past(W_REG, 4) & $past(INSTR[7:0], 4)) && ZERO_FLAG == (W_REG == 8'h00))
    else $error("and result wrong");
  a_illegal_flag: assert property (PHASE == 2'h0 |=> ILLEGAL_OP == !(
    $past(INSTR[13:9]) == 5'h1f || $past(INSTR[13:8]) == 6'h39
    || $past(INSTR[13:8]) == 6'h07)) else $error("illegal flag wrong");
  a_lit_sum: assert property (PHASE == 2'h0 && INSTR[13:9] == 5'h1f |-> ##4
    {CARRY_FLAG, W_REG} == {1'b0, $past(W_REG, 4)} + $past(INSTR[7:0], 4))
    else $error("literal sum wrong");
  a_reg_write: assert property (PHASE == 2'h0 && INSTR[13:8] == 6'h07 |-> ##3
    FILE_WE == $past(INSTR[7], 3) && (!FILE_WE || FILE_WDATA == $past(W_REG, 3)
    + $past(FILE_RDATA, 2))) else $error("file write wrong");
  a_reg_dest: assert property (PHASE == 2'h0 && INSTR[13:8] == 6'h07 |-> ##4
    W_REG == ($past(INSTR[7], 4) ? $past(W_REG, 4) : $past(W_REG, 4) + $past(FILE_RDATA, 3)))
    else $error("register sum wrong");
endmodule
bind alop_core alop_checker u_chk (.CLK(CLK), .RST(RST), .INSTR(INSTR), .FILE_ADDR(FILE_ADDR),
  .FILE_RDATA(FILE_RDATA), .FILE_WDATA(FILE_WDATA), .FILE_WE(FILE_WE), .PHASE(PHASE),
  .INSTR_START(INSTR_START), .W_REG(W_REG), .CARRY_FLAG(CARRY_FLAG),
  .NIBBLE_CARRY_FLAG(NIBBLE_CARRY_FLAG), .ZERO_FLAG(ZERO_FLAG), .ILLEGAL_OP(ILLEGAL_OP));

// *** verif/alop_file_model.sv ***
module alop_file_model (
  // file register port
  input  logic       clk,
  input  logic [6:0] addr,
  input  logic [7:0] wdata,
  input  logic       we,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:127];
  // distinct start value in every file
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 11);
  end
  // read is immediate, write lands at the edge
  assign rdata = mem[addr];
  always @(posedge clk) begin
    if (we) mem[addr] <= wdata;
  end
endmodule

// *** verif/add_and_literal_alu_ops_tb.sv ***
module add_and_literal_alu_ops_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, fwe, c, dc, z;
  logic [13:0] instr;
  logic [6:0]  fa;
  logic [7:0]  frd, fwd, w;
  logic [1:0]  ph;
  logic [10:0] st;
  logic [31:0] rs;
  int          miscompares, n_compared, cycles;
  logic [13:0] ops [4] = '{14'h3e00, 14'h3900, 14'h0700, 14'h3f00};
  logic [13:0] corner [8] = '{14'h3e10, 14'h3f15, 14'h3eda, 14'h3e01,
                             14'h3900, 14'h3a55, 14'h0785, 14'h0705};
  alop_core dut (.CLK(clk), .RST(rst), .INSTR(instr), .FILE_ADDR(fa), .FILE_RDATA(frd),
    .FILE_WDATA(fwd), .FILE_WE(fwe), .PHASE(ph), .INSTR_START(), .W_REG(w),
    .CARRY_FLAG(c), .NIBBLE_CARRY_FLAG(dc), .ZERO_FLAG(z), .ILLEGAL_OP());
  alop_file_model fm (.clk(clk), .addr(fa), .wdata(fwd), .we(fwe), .rdata(frd));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // next {c, dc, z, w} after one instruction
  function automatic logic [10:0] predict(input logic [13:0] i, input logic [10:0] s,
                                          input logic [7:0] f);
    logic [7:0] op;
    logic [8:0] sum;
    logic [4:0] lo;
    op = (i[13:12] == 2'h3) ? i[7:0] : f;
    sum = {1'b0, s[7:0]} + {1'b0, op};
    lo = {1'b0, s[3:0]} + {1'b0, op[3:0]};
    if (i[13:9] == 5'h1f || i[13:8] == 6'h07)
      return {sum[8], lo[4], sum[7:0] == 8'h00, (i[7] && !i[13]) ? s[7:0] : sum[7:0]};
    if (i[13:8] == 6'h39)
      return {s[10:9], (s[7:0] & i[7:0]) == 8'h00, s[7:0] & i[7:0]};
    return s;
  endfunction
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one instruction through its four phases
  task automatic run(input logic [13:0] i);
    logic [7:0] f;
    f = fm.mem[i[6:0]];
    instr <= i;
    repeat (4) @(posedge clk);
    #1;
    chk("state", predict(i, st, f), {c, dc, z, w});
    if (i[13:7] == 7'h0f) chk("file", {3'h0, f + st[7:0]}, {3'h0, fm.mem[i[6:0]]});
    st = predict(i, st, f);
  endtask
  // free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      end_of_test();
    end
  end
  // corner cases then random traffic
  initial begin
    rst = 1'b1;
    instr = 14'h0000;
    st = 11'h000;
    rs = 32'h0e4a52cc;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (corner[k]) run(corner[k]);
    repeat (200) begin
      rs = xs(rs);
      run(ops[rs[1:0]] | {6'h00, rs[15:8]});
    end
    end_of_test();
  end
endmodule
